// ==== hdl/cgc_defines.svh ====
// What this block does
// - enable field overrides select pins per input
// - both address pins high selects serial-peripheral
// - master starts transfers and drives serial clock
// - clock line input only, data open-drain
// - seven-bit address, upper 1101, lower from pins
// - start and stop detected with clock high
// - seven address bits then read/write bit
// - ninth bit acknowledges address, low means success
// - write sends register address, acknowledged next
// - data bytes stored up to final register, pointer advances by one
// - read first writes pointer, then restarts
// - read streams registers up to final register
// - monitor disabled when either input disabled
`ifndef CGC_DEFINES_SVH
`define CGC_DEFINES_SVH

`define CGC_ADDR_UPPER   4'hd
`define CGC_REG_COUNT    9
`define CGC_LAST_REG     8'h08
`define CGC_IE_REG       4'h5
`define CGC_IE_LSB       2
`define CGC_IE_PINS      2'h0
`define CGC_IE_ONLY0     2'h1
`define CGC_IE_ONLY1     2'h2
`define CGC_IE_BOTH      2'h3
`define CGC_REG_RESET    8'h00
`define CGC_PAST_END     8'hff
`define CGC_CLOCK_MHZ    100
`define CGC_SCL_PERIOD_NS 2500
`define CGC_SCL_QUARTER  (((`CGC_SCL_PERIOD_NS * `CGC_CLOCK_MHZ) / 4 + 999) / 1000)

`endif

// ==== hdl/cgc_link_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface cgc_link_if (
  input wire logic link_clock
);
  logic scl_drive;
  logic sda_host_out;
  logic sda_host_oe;
  logic sda_dev_out;
  logic sda_dev_oe;
  logic scl;
  logic sda;

  // wire levels, pull-up on the data line
  assign scl = scl_drive;
  assign sda = !((sda_host_oe && !sda_host_out) || (sda_dev_oe && !sda_dev_out));

  modport target (input link_clock, input scl, input sda, output sda_dev_out, output sda_dev_oe);
  modport master (input sda, output scl_drive, output sda_host_out, output sda_host_oe);
endinterface
`default_nettype wire

// ==== hdl/cgc_master.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "cgc_defines.svh"
module cgc_master
  import cgc_pkg::*;
(
  cgc_link_if.master      link,
  input  wire logic       clock,
  input  wire logic       arst_n,
  input  wire logic       cmd_valid,
  input  wire logic       cmd_read,
  input  wire logic [6:0] cmd_target,
  input  wire logic [7:0] cmd_reg,
  input  wire logic [3:0] cmd_len,
  input  wire logic [7:0] wr_data,
  output logic            cmd_ready,
  output logic            wr_next,
  output logic [7:0]      rd_data,
  output logic            rd_valid,
  output logic            done,
  output logic            nack_error
);

  cgc_step_type step;
  logic [7:0]   tick;
  logic [1:0]   phase;
  logic [3:0]   bit_idx;
  logic [7:0]   tx;
  logic [7:0]   rx;
  logic [3:0]   left;
  logic         is_read;
  logic [6:0]   target;
  logic [7:0]   regnum;
  logic         ack_bad;
  logic         sda_meta;
  logic         sda_in;
  logic         next_scl;
  logic         next_sda_oe;
  logic         quarter_end;

  // steps that move a whole byte
  function automatic logic byte_step(input cgc_step_type s);
    byte_step = (s != sp_idle) && (s != sp_start) && (s != sp_rstart) && (s != sp_stop);
  endfunction

  assign quarter_end = (tick == 8'(`CGC_SCL_QUARTER - 1));
  assign cmd_ready   = (step == sp_idle);

  // data line synchroniser
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sda_meta <= 1'b1;
      sda_in   <= 1'b1;
    end else begin
      sda_meta <= link.sda;
      sda_in   <= sda_meta;
    end
  end

  // line levels for each quarter of a bit
  always_comb begin
    next_scl    = 1'b1;
    next_sda_oe = 1'b0;
    case (step)
      sp_idle: ;
      sp_start, sp_rstart: begin
        next_scl    = (phase != 2'h0);
        next_sda_oe = phase[1];
      end
      sp_stop: begin
        next_scl    = phase[1];
        next_sda_oe = (phase != 2'h3);
      end
      default: begin
        next_scl = phase[1];
        if (bit_idx < 4'h8) begin
          next_sda_oe = (step != sp_rdata) && !tx[7];
        end else begin
          next_sda_oe = (step == sp_rdata) && (left != 4'h1);
        end
      end
    endcase
  end

  // registered pin drive
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      link.scl_drive   <= 1'b1;
      link.sda_host_oe <= 1'b0;
    end else begin
      link.scl_drive   <= next_scl;
      link.sda_host_oe <= next_sda_oe;
    end
  end
  assign link.sda_host_out = 1'b0;

  // transfer sequencer
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      step <= sp_idle;
      tick <= 8'h00;
      phase <= 2'h0;
      bit_idx <= 4'h0;
      tx <= 8'hff;
      rx <= 8'h00;
      left <= 4'h0;
      is_read <= 1'b0;
      target <= 7'h00;
      regnum <= 8'h00;
      ack_bad <= 1'b0;
      wr_next <= 1'b0;
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
      done <= 1'b0;
      nack_error <= 1'b0;
    end else begin
      wr_next  <= 1'b0;
      rd_valid <= 1'b0;
      done     <= 1'b0;
      if (step == sp_idle) begin
        if (cmd_valid) begin
          step       <= sp_start;
          is_read    <= cmd_read;
          target     <= cmd_target;
          regnum     <= cmd_reg;
          left       <= cmd_len;
          tick       <= 8'h00;
          phase      <= 2'h0;
          bit_idx    <= 4'h0;
          nack_error <= 1'b0;
        end
      end else begin
        tick <= quarter_end ? 8'h00 : tick + 8'h01;
        if (quarter_end) begin
          phase <= phase + 2'h1;
          if ((phase == 2'h2) && (bit_idx < 4'h8)) begin
            rx <= {rx[6:0], sda_in};
          end
          if ((phase == 2'h2) && (bit_idx == 4'h8) && (step != sp_rdata)) begin
            ack_bad <= sda_in;
            if (sda_in) begin
              nack_error <= 1'b1;
            end
          end
          if ((phase == 2'h3) && byte_step(step) && (bit_idx != 4'h8)) begin
            bit_idx <= bit_idx + 4'h1;
            tx      <= {tx[6:0], 1'b1};
          end else if (phase == 2'h3) begin
            bit_idx <= 4'h0;
            case (step)
              sp_start: begin
                step <= sp_addr_w;
                tx   <= {target, 1'b0};
              end
              sp_addr_w: begin
                step <= ack_bad ? sp_stop : sp_reg;
                tx   <= regnum;
              end
              sp_reg: begin
                if (ack_bad || (!is_read && (left == 4'h0))) begin
                  step <= sp_stop;
                end else if (is_read) begin
                  step <= sp_rstart;
                end else begin
                  step    <= sp_wdata;
                  tx      <= wr_data;
                  wr_next <= 1'b1;
                end
              end
              sp_wdata: begin
                left <= left - 4'h1;
                if (ack_bad || (left == 4'h1)) begin
                  step <= sp_stop;
                end else begin
                  tx      <= wr_data;
                  wr_next <= 1'b1;
                end
              end
              sp_rstart: begin
                step <= sp_addr_r;
                tx   <= {target, 1'b1};
              end
              sp_addr_r: begin
                step <= (ack_bad || (left == 4'h0)) ? sp_stop : sp_rdata;
                tx   <= 8'hff;
              end
              sp_rdata: begin
                rd_data  <= rx;
                rd_valid <= 1'b1;
                left     <= left - 4'h1;
                if (left == 4'h1) begin
                  step <= sp_stop;
                end
              end
              default: begin
                step <= sp_idle;
                done <= 1'b1;
              end
            endcase
          end
        end
      end
    end
  end

endmodule
`default_nettype wire

// ==== hdl/cgc_pkg.sv ====
package cgc_pkg;

  // three-level strap pin
  typedef enum logic [1:0] {cgc_low, cgc_open, cgc_high} cgc_level_type;

  // target protocol states
  typedef enum logic [2:0] {st_idle, st_addr, st_regp, st_wr, st_rd} cgc_tgt_state_type;

  // master sequence steps
  typedef enum logic [3:0] {
    sp_idle, sp_start, sp_addr_w, sp_reg, sp_wdata,
    sp_rstart, sp_addr_r, sp_rdata, sp_stop
  } cgc_step_type;

endpackage

// ==== hdl/cgc_target.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "cgc_defines.svh"
module cgc_target
  import cgc_pkg::*;
(
  cgc_link_if.target         link,
  input  wire logic          clock,
  input  wire logic          arst_n,
  input  wire cgc_level_type address_select_pin_0,
  input  wire cgc_level_type address_select_pin_1,
  input  wire logic          input_select_pin_0,
  input  wire logic          input_select_pin_1,
  output logic               reference_input_0_enable,
  output logic               reference_input_1_enable,
  output logic               monitor_enable,
  output logic               spi_mode,
  output logic [1:0]         input_enable_field
);

  // ---------------- link domain ----------------
  logic [1:0]        scl_sync;
  logic [1:0]        sda_sync;
  logic              scl_prev;
  logic              sda_prev;
  cgc_level_type     ad0_meta;
  cgc_level_type     ad0;
  cgc_level_type     ad1_meta;
  cgc_level_type     ad1;
  cgc_tgt_state_type state;
  logic [3:0]        bit_cnt;
  logic [7:0]        shreg;
  logic [7:0]        tx;
  logic [7:0]        ptr;
  logic              rw;
  logic              master_nack;
  logic              sda_low;
  logic [7:0]        regs [0:`CGC_REG_COUNT-1];
  logic              scl_rise;
  logic              scl_fall;
  logic              start_seen;
  logic              stop_seen;
  logic              spi_link;
  logic              addr_hit;
  logic              ptr_ok;
  logic [7:0]        rd_byte;
  logic              reg_we;

  // lower address bits from the two three-level straps
  function automatic logic [2:0] low_bits(input cgc_level_type a0, input cgc_level_type a1);
    low_bits = ({1'b0, a0} * 3'h3) + {1'b0, a1};
  endfunction

  // two-flop synchronisers for the bus lines and straps
  always_ff @(posedge link.link_clock or negedge arst_n) begin
    if (!arst_n) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
      ad0_meta <= cgc_low;
      ad0      <= cgc_low;
      ad1_meta <= cgc_low;
      ad1      <= cgc_low;
    end else begin
      scl_sync <= {scl_sync[0], link.scl};
      sda_sync <= {sda_sync[0], link.sda};
      scl_prev <= scl_sync[1];
      sda_prev <= sda_sync[1];
      ad0_meta <= address_select_pin_0;
      ad0      <= ad0_meta;
      ad1_meta <= address_select_pin_1;
      ad1      <= ad1_meta;
    end
  end

  // line events, all from settled samples
  assign scl_rise   = scl_sync[1] && !scl_prev;
  assign scl_fall   = !scl_sync[1] && scl_prev;
  assign start_seen = scl_sync[1] && scl_prev && sda_prev && !sda_sync[1];
  assign stop_seen  = scl_sync[1] && scl_prev && !sda_prev && sda_sync[1];
  assign spi_link   = (ad0 == cgc_high) && (ad1 == cgc_high);
  assign addr_hit   = (shreg[7:1] == {`CGC_ADDR_UPPER, low_bits(ad0, ad1)});
  assign ptr_ok     = (ptr <= `CGC_LAST_REG);
  assign rd_byte    = ptr_ok ? regs[ptr[3:0]] : `CGC_PAST_END;
  assign reg_we     = scl_fall && (bit_cnt == 4'h8) && (state == st_wr) && ptr_ok;

  // session state machine: bits counted on rising clock, driven on falling
  always_ff @(posedge link.link_clock or negedge arst_n) begin
    if (!arst_n) begin
      state       <= st_idle;
      bit_cnt     <= 4'h0;
      shreg       <= 8'h00;
      tx          <= 8'hff;
      ptr         <= 8'h00;
      rw          <= 1'b0;
      master_nack <= 1'b0;
      sda_low     <= 1'b0;
    end else if (stop_seen || spi_link) begin
      state   <= st_idle;
      bit_cnt <= 4'h0;
      sda_low <= 1'b0;
    end else if (start_seen) begin
      state   <= st_addr;
      bit_cnt <= 4'h0;
      sda_low <= 1'b0;
    end else if (state != st_idle) begin
      if (scl_rise) begin
        if (bit_cnt < 4'h8) begin
          shreg <= {shreg[6:0], sda_sync[1]};
        end else if (bit_cnt == 4'h8) begin
          master_nack <= sda_sync[1];
        end
        bit_cnt <= bit_cnt + 4'h1;
      end
      if (scl_fall) begin
        if (bit_cnt == 4'h8) begin
          // byte complete: decide the acknowledge
          case (state)
            st_addr: begin
              rw      <= shreg[0];
              sda_low <= addr_hit;
              if (!addr_hit) begin
                state <= st_idle;
              end
            end
            st_regp: begin
              ptr     <= shreg;
              sda_low <= 1'b1;
            end
            st_wr: begin
              sda_low <= ptr_ok;
              if (ptr_ok) begin
                ptr <= ptr + 8'h01;
              end
            end
            default: sda_low <= 1'b0;
          endcase
        end else if (bit_cnt == 4'h9) begin
          // acknowledge over: move on
          bit_cnt <= 4'h0;
          sda_low <= 1'b0;
          case (state)
            st_addr: begin
              if (rw) begin
                state   <= st_rd;
                tx      <= rd_byte;
                sda_low <= !rd_byte[7];
                if (ptr_ok) begin
                  ptr <= ptr + 8'h01;
                end
              end else begin
                state <= st_regp;
              end
            end
            st_regp: state <= st_wr;
            st_rd: begin
              if (master_nack) begin
                state <= st_idle;
              end else begin
                tx      <= rd_byte;
                sda_low <= !rd_byte[7];
                if (ptr_ok) begin
                  ptr <= ptr + 8'h01;
                end
              end
            end
            default: ;
          endcase
        end else if ((state == st_rd) && (bit_cnt != 4'h0)) begin
          tx      <= {tx[6:0], 1'b1};
          sda_low <= !tx[6];
        end
      end
    end
  end

  // open-drain data line, never driven high
  assign link.sda_dev_out = 1'b0;
  assign link.sda_dev_oe  = sda_low;

  // register map storage
  always_ff @(posedge link.link_clock or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < `CGC_REG_COUNT; i++) begin
        regs[i] <= `CGC_REG_RESET;
      end
    end else if (reg_we) begin
      regs[ptr[3:0]] <= shreg;
    end
  end

  // ---------------- system clock domain ----------------
  logic [1:0] ie_meta;
  logic [1:0] ie;
  logic [1:0] sel_meta;
  logic [1:0] sel;
  logic       spi_meta;
  logic       spi;
  logic       next_en0;
  logic       next_en1;

  // level crossings; field is quasi-static so per-bit sync is enough
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ie_meta  <= 2'h0;
      ie       <= 2'h0;
      sel_meta <= 2'h0;
      sel      <= 2'h0;
      spi_meta <= 1'b0;
      spi      <= 1'b0;
    end else begin
      ie_meta  <= regs[`CGC_IE_REG][`CGC_IE_LSB +: 2];
      ie       <= ie_meta;
      sel_meta <= {input_select_pin_1, input_select_pin_0};
      sel      <= sel_meta;
      spi_meta <= spi_link;
      spi      <= spi_meta;
    end
  end

  // reference input enables
  always_comb begin
    next_en0 = sel[0];
    next_en1 = sel[1];
    case (ie)
      `CGC_IE_ONLY0: begin next_en0 = 1'b1; next_en1 = 1'b0; end
      `CGC_IE_ONLY1: begin next_en0 = 1'b0; next_en1 = 1'b1; end
      `CGC_IE_BOTH:  begin next_en0 = 1'b1; next_en1 = 1'b1; end
      default: ;
    endcase
  end

  // registered user outputs
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      reference_input_0_enable <= 1'b0;
      reference_input_1_enable <= 1'b0;
      monitor_enable           <= 1'b0;
      spi_mode                 <= 1'b0;
      input_enable_field       <= 2'h0;
    end else begin
      reference_input_0_enable <= next_en0;
      reference_input_1_enable <= next_en1;
      monitor_enable           <= next_en0 && next_en1;
      spi_mode                 <= spi;
      input_enable_field       <= ie;
    end
  end

endmodule
`default_nettype wire

// ==== testbench/cgc_link_checker.sv ====
`timescale 1ns/10ps
`default_nettype none
module cgc_link_checker (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_dev_oe
);
  logic       scl_q;
  logic       sda_q;
  logic       oe_q;
  logic       rd_ses;
  logic       foreign;
  logic       rd_nak;
  logic       rise;
  logic       strt;
  logic [7:0] cnt;
  logic [7:0] sh;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  // wire events
  assign rise = scl && !scl_q;
  assign strt = scl && scl_q && sda_q && !sda;

  // previous wire levels
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      oe_q  <= 1'b0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      oe_q  <= sda_dev_oe;
    end
  end

  // bit position and shifted bits of the session
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 8'h00;
      sh  <= 8'h00;
    end else if (strt) begin
      cnt <= 8'h00;
    end else if (rise) begin
      cnt <= cnt + 8'h01;
      sh  <= {sh[6:0], sda};
    end
  end

  // session kind, fixed at the address acknowledge
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rd_ses  <= 1'b0;
      foreign <= 1'b0;
      rd_nak  <= 1'b0;
    end else if (strt) begin
      rd_ses  <= 1'b0;
      foreign <= 1'b0;
      rd_nak  <= 1'b0;
    end else if (rise && cnt == 8'h08) begin
      rd_ses  <= sh[0] && !sda;
      foreign <= sda;
    end else if (rise && rd_ses && cnt % 8'h09 == 8'h08 && sda) begin
      rd_nak <= 1'b1;
    end
  end

  chk_oe_scl_low : assert property ($changed(sda_dev_oe) |-> !scl)
    else $error("target data drive changed with clock high");
  chk_no_false_cond : assert property (scl && scl_q && sda != sda_q |-> !sda_dev_oe && !oe_q)
    else $error("target made a start or stop");
  chk_addr_quiet : assert property (rise && cnt < 8'h08 |-> !sda_dev_oe)
    else $error("target drove an address bit");
  chk_upper_addr : assert property (rise && cnt == 8'h08 && sh[7:4] != 4'hd |-> !sda_dev_oe)
    else $error("target answered a wrong upper address");
  chk_foreign_quiet : assert property (foreign |-> !sda_dev_oe)
    else $error("target drove in a foreign session");
  chk_reg_ack : assert property (rise && !rd_ses && !foreign && cnt == 8'h11 && sh <= 8'h08
    |-> !sda)
    else $error("register byte not acknowledged");
  chk_write_quiet : assert property (rise && !rd_ses && cnt % 8'h09 != 8'h08 |-> !sda_dev_oe)
    else $error("target drove a write data bit");
  chk_nack_release : assert property (rd_nak |-> !sda_dev_oe)
    else $error("target kept driving after a refused byte");

  cov_read : cover property (rise && rd_ses && cnt == 8'h11);
  cov_foreign : cover property (foreign);
  cov_nack : cover property (rd_nak);
endmodule
`default_nettype wire

// ==== testbench/tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "cgc_defines.svh"
module tb_top
  import cgc_pkg::*;
;
  logic          clock;
  logic          link_clock;
  logic          arst_n;
  logic          cmd_valid;
  logic          cmd_read;
  logic [6:0]    cmd_target;
  logic [7:0]    cmd_reg;
  logic [3:0]    cmd_len;
  logic [7:0]    wr_data;
  logic          cmd_ready;
  logic          wr_next;
  logic [7:0]    rd_data;
  logic          rd_valid;
  logic          done;
  logic          nack_error;
  cgc_level_type address_select_pin_0;
  cgc_level_type address_select_pin_1;
  logic          input_select_pin_0;
  logic          input_select_pin_1;
  logic          reference_input_0_enable;
  logic          reference_input_1_enable;
  logic          monitor_enable;
  logic          spi_mode;
  logic [1:0]    input_enable_field;
  logic          sc;
  logic          sd;
  logic          scl_p;
  logic          sda_p;
  logic [7:0]    wbyte;
  logic [7:0]    wcnt;
  logic [7:0]    rq[$];
  logic [7:0]    nq[$];
  int            n_errors;
  int            num_checks;

  cgc_link_if i_cgc_link_if (.link_clock(link_clock));
  cgc_target i_cgc_target (.link(i_cgc_link_if), .*);
  cgc_master i_cgc_master (.link(i_cgc_link_if), .*);
  cgc_link_checker i_cgc_link_checker (.clock(clock), .arst_n(arst_n), .scl(sc), .sda(sd),
    .sda_dev_oe(i_cgc_link_if.sda_dev_oe));
  assign sc = i_cgc_link_if.scl;
  assign sd = i_cgc_link_if.sda;

  // clocks, link clock offset in phase
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    link_clock = 1'b0;
    #7;
    forever #40 link_clock = ~link_clock;
  end

  // first byte of the latest session on the wire
  always @(posedge clock) begin
    scl_p <= sc;
    sda_p <= sd;
    if (sc && scl_p && sda_p && !sd) begin
      wcnt <= 8'h00;
    end else if (sc && !scl_p && wcnt < 8'h08) begin
      wbyte <= {wbyte[6:0], sd};
      wcnt  <= wcnt + 8'h01;
    end
  end

  // own address from the straps
  function automatic logic [6:0] me();
    return {`CGC_ADDR_UPPER, 3'(int'(address_select_pin_0) * 3 + int'(address_select_pin_1))};
  endfunction

  task automatic check_bit(input string nm, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic check_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // one command through the host port, read bytes into rq
  task automatic xfer(input logic rd, input logic [6:0] tg, input logic [7:0] rg,
                      input logic [3:0] len, input logic [7:0] wb[$]);
    int idx;
    int guard;
    idx = 0;
    guard = 0;
    rq.delete();
    @(posedge clock);
    cmd_valid  <= 1'b1;
    cmd_read   <= rd;
    cmd_target <= tg;
    cmd_reg    <= rg;
    cmd_len    <= len;
    wr_data    <= wb.size() > 0 ? wb[0] : 8'h00;
    @(negedge clock);
    while (cmd_ready !== 1'b1) @(negedge clock);
    @(posedge clock);
    cmd_valid <= 1'b0;
    @(negedge clock);
    check_bit("cmd_ready", 1'b0, cmd_ready);
    while (guard < 40000 && done !== 1'b1) begin
      @(negedge clock);
      guard++;
      if (rd_valid === 1'b1) rq.push_back(rd_data);
      if (wr_next === 1'b1) begin
        idx++;
        @(posedge clock);
        wr_data <= idx < wb.size() ? wb[idx] : 8'h00;
      end
    end
    check_bit("done", 1'b1, done);
    repeat (30) @(posedge clock);
  endtask

  task automatic ce(input logic [1:0] f, input logic r0, input logic r1);
    check_byte("field", {6'h00, f}, {6'h00, input_enable_field});
    check_bit("ref0 enable", r0, reference_input_0_enable);
    check_bit("ref1 enable", r1, reference_input_1_enable);
    check_bit("monitor", r0 && r1, monitor_enable);
  endtask

  task automatic t_write_incr();
    check_bit("scl idle", 1'b1, sc);
    check_bit("sda idle", 1'b1, sd);
    ce(2'h0, 1'b1, 1'b1);
    xfer(1'b0, me(), 8'h04, 4'h2, '{8'ha5, 8'h04});
    check_bit("nack_error", 1'b0, nack_error);
    ce(2'h1, 1'b1, 1'b0);
    $display("test write_incr done");
  endtask

  task automatic t_field_modes();
    logic [1:0] f;
    for (int i = 2; i < 5; i++) begin
      f = 2'(i);
      if (i == 3) begin
        @(posedge clock);
        input_select_pin_0 <= 1'b0;
        input_select_pin_1 <= 1'b0;
      end
      xfer(1'b0, me(), 8'h05, 4'h1, '{{4'h0, f, 2'h0}});
      ce(f, f[0], f[1]);
    end
    for (int p = 0; p < 4; p++) begin
      @(posedge clock);
      input_select_pin_0 <= p[0];
      input_select_pin_1 <= p[1];
      repeat (30) @(posedge clock);
      ce(2'h0, p[0], p[1]);
    end
    $display("test field_modes done");
  endtask

  task automatic t_read_stream();
    logic [7:0] ex[5];
    ex = '{8'ha5, 8'h00, 8'h00, 8'h00, 8'h00};
    xfer(1'b1, me(), 8'h04, 4'h5, nq);
    check_byte("read count", 8'h05, 8'(rq.size()));
    for (int i = 0; i < 5; i++) begin
      check_byte("read byte", ex[i], rq[i]);
    end
    check_byte("wire address", {me(), 1'b1}, wbyte);
    check_bit("nack_error", 1'b0, nack_error);
    $display("test read_stream done");
  endtask

  task automatic t_foreign();
    xfer(1'b0, me() ^ 7'h01, 8'h05, 4'h1, '{8'h0c});
    check_bit("nack_error", 1'b1, nack_error);
    check_byte("wire address", {me() ^ 7'h01, 1'b0}, wbyte);
    xfer(1'b0, me() ^ 7'h40, 8'h05, 4'h1, '{8'h0c});
    check_bit("nack_error", 1'b1, nack_error);
    ce(2'h0, 1'b1, 1'b1);
    $display("test foreign done");
  endtask

  task automatic t_spi();
    logic [6:0] old;
    old = me();
    @(posedge clock);
    address_select_pin_0 <= cgc_high;
    address_select_pin_1 <= cgc_high;
    repeat (30) @(posedge clock);
    check_bit("spi_mode", 1'b1, spi_mode);
    xfer(1'b0, old, 8'h05, 4'h1, '{8'h0c});
    check_bit("nack_error", 1'b1, nack_error);
    @(posedge clock);
    address_select_pin_1 <= cgc_low;
    repeat (30) @(posedge clock);
    check_bit("spi_mode", 1'b0, spi_mode);
    xfer(1'b0, me(), 8'h05, 4'h1, '{8'h04});
    check_bit("nack_error", 1'b0, nack_error);
    ce(2'h1, 1'b1, 1'b0);
    $display("test spi done");
  endtask

  // watchdog against a hung transfer
  initial begin
    #950000;
    n_errors++;
    $display("mismatch watchdog expected finish seen timeout");
    results();
  end

  // reset, then the scenarios
  initial begin
    n_errors = 0;
    num_checks = 0;
    arst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_read = 1'b0;
    cmd_target = 7'h00;
    cmd_reg = 8'h00;
    cmd_len = 4'h0;
    wr_data = 8'h00;
    address_select_pin_0 = cgc_open;
    address_select_pin_1 = cgc_high;
    input_select_pin_0 = 1'b1;
    input_select_pin_1 = 1'b1;
    repeat (5) @(posedge link_clock);
    @(posedge clock);
    arst_n <= 1'b1;
    repeat (40) @(posedge clock);
    t_write_incr();
    t_field_modes();
    t_read_stream();
    t_foreign();
    t_spi();
    results();
  end
endmodule
`default_nettype wire
